/* hdl/hfss_pkg.sv */
/*
 package for the hall sensor supervisor host: pulse timings, blanking wait, defaults.
 assumes a 25 MHz clk_sys.
*/
package hfss_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   // restart pulse window, 10 to 20 us, aim inside it
   localparam int unsigned RESTART_MIN_NS  = 10_000;
   localparam int unsigned RESTART_MAX_NS  = 20_000;
   localparam int unsigned RESTART_MIN_CYC = (RESTART_MIN_NS * 25 + 999) / 1000;
   localparam int unsigned RESTART_MAX_CYC = (RESTART_MAX_NS * 25) / 1000;
   localparam int unsigned RESTART_CYC     = (RESTART_MIN_CYC + RESTART_MAX_CYC) / 2;
   // sleep entry needs low longer than 40 us
   localparam int unsigned SLEEP_MIN_NS    = 40_000;
   localparam int unsigned SLEEP_CYC       = (SLEEP_MIN_NS * 25 + 999) / 1000 + 1;
   // blanking wait after wake or restart, 50 us least
   localparam int unsigned BLANK_NS        = 50_000;
   localparam int unsigned BLANK_CYC       = (BLANK_NS * 25 + 999) / 1000;
   // status sample filter depth
   localparam int unsigned FILT_LEN        = 4;
   localparam logic [1:0]  ST_NORMAL       = 2'h0;
   localparam logic [1:0]  ST_FAULT_LOW    = 2'h1;
   localparam logic [1:0]  ST_FAULT_HIZ    = 2'h2;
endpackage

/* hdl/hfss_filter.sv */
/*
 debounce of one status line read from the device.
 assumes the input is already synchronous to clk_sys.
*/
`timescale 1ns/10ps
module hfss_filter #(
   parameter int unsigned LEN = hfss_pkg::FILT_LEN
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   import hfss_pkg::*;
   logic [7:0] cnt_reg, cnt_next;
   logic       q_reg, q_next;

   // level must differ for LEN cycles before it is taken
   always_comb begin
      cnt_next = 8'h00;
      q_next   = q_reg;
      if (din != q_reg) begin
         cnt_next = cnt_reg + 8'h01;
         if (cnt_reg == 8'(LEN - 1)) begin
            q_next   = din;
            cnt_next = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_reg <= 8'h00;
         q_reg   <= 1'b1;
      end else begin
         cnt_reg <= cnt_next;
         q_reg   <= q_next;
      end
   end

   assign dout = q_reg;
endmodule // hfss_filter

/* hdl/hfss_host.sv */
/*
 host controller for the dual two-wire hall sensor interface: drives the active-low
 sleep pin, issues restart pulses, waits out blanking and classifies each channel.
 assumes status_out pins pulled up externally and read synchronously; mirror outputs
 digitised elsewhere into a single "mirror nonzero" flag per channel.
*/
`timescale 1ns/10ps
module hfss_host #(
   parameter int unsigned BLANK_CYCLES = hfss_pkg::BLANK_CYC,
   parameter int unsigned SLEEP_CYCLES = hfss_pkg::SLEEP_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       req_wake,
   input  wire logic       req_sleep,
   input  wire logic       req_restart,
   input  wire logic       status_out_ch1,
   input  wire logic       status_out_ch2,
   input  wire logic       mirror_on_ch1,
   input  wire logic       mirror_on_ch2,
   output logic            sleep_n_out,
   output logic            busy,
   output logic            ready,
   output logic            sensor_ch1,
   output logic            sensor_ch2,
   output logic [1:0]      state_ch1,
   output logic [1:0]      state_ch2
);
   import hfss_pkg::*;

   typedef enum logic [2:0] {
      HS_ASLEEP  = 3'b000,
      HS_BLANK   = 3'b001,
      HS_RUN     = 3'b010,
      HS_PULSE   = 3'b011,
      HS_SLEEPGO = 3'b100
   } hfss_state_t;

   hfss_state_t st_reg, st_next;
   logic [15:0] cnt_reg, cnt_next;
   logic        sl_reg, sl_next;
   logic [1:0]  f_sts;
   logic [1:0]  sts_in;
   logic [15:0] low_len_reg, low_len_next;
   logic [1:0]  mir;
   logic [1:0]  cls_reg [2];
   logic [1:0]  cls_next [2];
   logic [1:0]  sen_reg, sen_next;

   // pins gathered per channel for the generate loop
   assign mir    = {mirror_on_ch2, mirror_on_ch1};
   assign sts_in = {status_out_ch2, status_out_ch1};

   // sleep pin sequencer
   always_comb begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      sl_next  = sl_reg;
      unique case (st_reg)
         HS_ASLEEP: begin
            sl_next = 1'b0;
            if (req_wake) begin
               st_next  = HS_BLANK;
               sl_next  = 1'b1;
               cnt_next = 16'h0000;
            end
         end
         HS_BLANK: begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == 16'(BLANK_CYCLES - 1)) begin
               st_next = HS_RUN;
            end
         end
         HS_RUN: begin
            if (req_sleep) begin
               st_next  = HS_SLEEPGO;
               sl_next  = 1'b0;
               cnt_next = 16'h0000;
            end else if (req_restart) begin
               st_next  = HS_PULSE;
               sl_next  = 1'b0;
               cnt_next = 16'h0000;
            end
         end
         HS_PULSE: begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == 16'(RESTART_CYC - 1)) begin
               st_next  = HS_BLANK;
               sl_next  = 1'b1;
               cnt_next = 16'h0000;
            end
         end
         HS_SLEEPGO: begin
            cnt_next = cnt_reg + 16'h0001;
            if (cnt_reg == 16'(SLEEP_CYCLES - 1)) begin
               st_next = HS_ASLEEP;
            end
         end
         default: begin
            st_next = HS_ASLEEP;
            sl_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg  <= HS_ASLEEP;
         cnt_reg <= 16'h0000;
         sl_reg  <= 1'b0;
      end else begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         sl_reg  <= sl_next;
      end
   end

   // per channel classification, only while running
   generate
      for (genvar i = 0; i < 2; i++) begin : g_ch
         // filtered copy of this channel's status pin
         hfss_filter #(.LEN(FILT_LEN)) hfss_filter_i (
            .clk_sys (clk_sys),
            .rst     (rst),
            .din     (sts_in[i]),
            .dout    (f_sts[i])
         );
         always_comb begin
            cls_next[i] = cls_reg[i];
            sen_next[i] = sen_reg[i];
            if (st_reg == HS_RUN) begin
               if (f_sts[i] && !mir[i]) begin
                  cls_next[i] = ST_FAULT_HIZ;
               end else if (!f_sts[i] && !mir[i]) begin
                  cls_next[i] = ST_FAULT_LOW;
               end else begin
                  cls_next[i] = ST_NORMAL;
                  sen_next[i] = f_sts[i];
               end
            end
         end
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               cls_reg[i] <= ST_NORMAL;
               sen_reg[i] <= 1'b0;
            end else begin
               cls_reg[i] <= cls_next[i];
               sen_reg[i] <= sen_next[i];
            end
         end
      end
   endgenerate

   assign sleep_n_out = sl_reg;
   assign busy        = (st_reg != HS_RUN) && (st_reg != HS_ASLEEP);
   assign ready       = (st_reg == HS_RUN);
   assign sensor_ch1  = sen_reg[0];
   assign sensor_ch2  = sen_reg[1];
   assign state_ch1   = cls_reg[0];
   assign state_ch2   = cls_reg[1];

   // length of the present low stretch on the sleep pin, saturating, counted apart from the sequencer
   always_comb begin
      low_len_next = low_len_reg;
      if (sl_reg) begin
         low_len_next = 16'h0000;
      end else if (low_len_reg != 16'hffff) begin
         low_len_next = low_len_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         low_len_reg <= 16'h0000;
      end else begin
         low_len_reg <= low_len_next;
      end
   end

   // restart pulse measured on the pin lies inside 10..20 us
   property p_pulse_len;
      @(posedge clk_sys) disable iff (rst)
         $rose(sl_reg) && $past(st_reg) == HS_PULSE |->
            low_len_reg >= 16'(RESTART_MIN_CYC) && low_len_reg <= 16'(RESTART_MAX_CYC);
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("restart pulse too short");

   property p_pulse_end;
      @(posedge clk_sys) disable iff (rst)
         $rose(sl_reg) && $past(st_reg) == HS_PULSE |-> st_reg == HS_BLANK && cnt_reg == 16'h0000;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse end not followed by blanking");

   property p_pulse_low;
      @(posedge clk_sys) disable iff (rst)
         st_reg == HS_PULSE |-> !sl_reg;
   endproperty
   a_pulse_low: assert property (p_pulse_low) else $error("sleep pin high during pulse");

   property p_sleep_hold;
      @(posedge clk_sys) disable iff (rst)
         st_reg == HS_SLEEPGO |-> !sl_reg && cnt_reg < 16'(SLEEP_CYCLES);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep entry hold broken");

   property p_asleep_low;
      @(posedge clk_sys) disable iff (rst)
         st_reg == HS_ASLEEP && $past(st_reg) == HS_SLEEPGO |-> $past(cnt_reg) == 16'(SLEEP_CYCLES - 1);
   endproperty
   a_asleep_low: assert property (p_asleep_low) else $error("asleep before 40 us");

   property p_blank_quiet;
      @(posedge clk_sys) disable iff (rst)
         st_reg == HS_BLANK |=> $stable(cls_reg[0]) && $stable(cls_reg[1]);
   endproperty
   a_blank_quiet: assert property (p_blank_quiet) else $error("classified during blanking");

   property p_run_after_blank;
      @(posedge clk_sys) disable iff (rst)
         st_reg == HS_RUN && $past(st_reg) == HS_BLANK |-> $past(cnt_reg) == 16'(BLANK_CYCLES - 1);
   endproperty
   a_run_after_blank: assert property (p_run_after_blank) else $error("blanking cut short");

   property p_hiz_class;
      @(posedge clk_sys) disable iff (rst)
         st_reg == HS_RUN && f_sts[0] && !mir[0] |=> cls_reg[0] == ST_FAULT_HIZ;
   endproperty
   a_hiz_class: assert property (p_hiz_class) else $error("short fault not reported");
endmodule // hfss_host

/* dv/hfss_dev_model.sv */
/*
 behavioural model of the dual two-wire hall sensor interface device.
 assumes times in clk_sys cycles; status lines pulled up, so high-z reads 1.
*/
`timescale 1ns/10ps
module hfss_dev_model #(
   parameter int SLEEP_LIM = 1000,
   parameter int RST_MIN   = 250,
   parameter int RST_MAX   = 500,
   parameter int BLANK     = 2,
   parameter int OPEN_LIM  = 20
) (
   input  wire logic       clk_sys,
   input  wire logic       sleep_n,
   input  wire logic [1:0] sense,
   input  wire logic [1:0] short_gnd,
   input  wire logic [1:0] open_in,
   output logic            status_out_ch1,
   output logic            status_out_ch2,
   output logic            mirror_on_ch1,
   output logic            mirror_on_ch2
);
   int   low_cnt = 0;
   logic asleep  = 1'b1;
   logic prev_n  = 1'b0;
   int   blank[2]    = '{0, 0};
   int   open_cnt[2] = '{0, 0};
   logic latch[2]    = '{1'b0, 1'b0};
   logic openf[2]    = '{1'b0, 1'b0};
   logic [1:0] st;
   logic [1:0] mr;

   // sleep pin timing and per channel fault tracking
   always @(posedge clk_sys) begin
      if (sleep_n !== 1'b1) begin // undriven pin reads low, as with its pull-down
         low_cnt++;
         if (low_cnt > SLEEP_LIM) asleep = 1'b1;
      end else if (!prev_n) begin
         for (int i = 0; i < 2; i++) begin
            if (asleep || (latch[i] && low_cnt >= RST_MIN && low_cnt <= RST_MAX)) begin
               latch[i] = 1'b0;
               blank[i] = BLANK;
            end
         end
         asleep  = 1'b0;
         low_cnt = 0;
      end
      prev_n = sleep_n;
      for (int i = 0; i < 2; i++) begin
         if (open_in[i]) begin
            if (open_cnt[i] < OPEN_LIM) open_cnt[i]++;
            else begin
               openf[i] = 1'b1;
               latch[i] = 1'b0;
            end
         end else begin
            open_cnt[i] = 0;
            if (openf[i]) begin
               openf[i] = 1'b0;
               blank[i] = BLANK;
            end
         end
         if (blank[i] > 0) blank[i]--;
         else if (short_gnd[i] && !openf[i] && !asleep) latch[i] = 1'b1;
      end
      // output levels for each condition, updated after the edge so the host never races them
      for (int i = 0; i < 2; i++) begin
         mr[i] <= !(asleep || latch[i] || openf[i]);
         st[i] <= (asleep || latch[i]) ? 1'b1 : openf[i] ? 1'b0 : (blank[i] > 0) ? 1'b1 : sense[i];
      end
   end
   assign status_out_ch1 = st[0];
   assign status_out_ch2 = st[1];
   assign mirror_on_ch1  = mr[0];
   assign mirror_on_ch2  = mr[1];
endmodule // hfss_dev_model

/* dv/hall_fault_sleep_supervisor_test.sv */
/*
 self-checking bench for the hall sensor supervisor host.
 assumes the device model in dv and the host design in hdl.
*/
`timescale 1ns/10ps
module hall_fault_sleep_supervisor_test;
   import hfss_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, req_wake = 1'b0, req_sleep = 1'b0, req_restart = 1'b0;
   logic [1:0] sense = 2'h0, short_gnd = 2'h0, open_in = 2'h0;
   logic s1, s2, m1, m2, sleep_n_out, busy, ready, sensor_ch1, sensor_ch2;
   logic [1:0] state_ch1, state_ch2;
   int n_errors = 0;
   int checks = 0;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
   $display("ERROR at %0t: mismatch on line %0d", $time, `__LINE__); end end

   hfss_host #(.BLANK_CYCLES(8), .SLEEP_CYCLES(4)) hfss_host_i (.clk_sys(clk_sys), .rst(rst),
      .req_wake(req_wake), .req_sleep(req_sleep), .req_restart(req_restart), .status_out_ch1(s1),
      .status_out_ch2(s2), .mirror_on_ch1(m1), .mirror_on_ch2(m2), .sleep_n_out(sleep_n_out),
      .busy(busy), .ready(ready), .sensor_ch1(sensor_ch1), .sensor_ch2(sensor_ch2),
      .state_ch1(state_ch1), .state_ch2(state_ch2));
   hfss_dev_model hfss_dev_model_i (.clk_sys(clk_sys), .sleep_n(sleep_n_out), .sense(sense),
      .short_gnd(short_gnd), .open_in(open_in), .status_out_ch1(s1), .status_out_ch2(s2),
      .mirror_on_ch1(m1), .mirror_on_ch2(m2));

   // clock generation
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic wait_ready(input int lim);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < lim) begin
         tick(1);
         k++;
      end
      `CHK(ready, 1'b1)
   endtask

   // wake from reset, pin released on the same edge that takes the request
   task automatic t_wake;
      `CHK(sleep_n_out, 1'b0)
      req_wake = 1'b1;
      tick(1);
      req_wake = 1'b0;
      tick(1);
      `CHK(sleep_n_out, 1'b1)
      `CHK(busy, 1'b1)
      wait_ready(40);
      tick(8);
   endtask

   // every sensor pattern reaches the outputs
   task automatic t_sense;
      for (int p = 0; p < 4; p++) begin
         sense = p[1:0];
         tick(8);
         `CHK({sensor_ch2, sensor_ch1}, p[1:0])
      end
   endtask

   // short on channel 1, cleared by a restart pulse
   task automatic t_restart;
      short_gnd = 2'h1;
      tick(10);
      `CHK(state_ch1, ST_FAULT_HIZ)
      `CHK(state_ch2, ST_NORMAL)
      short_gnd = 2'h0;
      req_restart = 1'b1;
      tick(1);
      req_restart = 1'b0;
      tick(1);
      `CHK(sleep_n_out, 1'b0)
      tick(RESTART_CYC - 10);
      `CHK(sleep_n_out, 1'b0)
      wait_ready(RESTART_CYC + 60);
      tick(8);
      `CHK(state_ch1, ST_NORMAL)
      `CHK(sensor_ch2, 1'b1)
   endtask

   // manual clear: short, open, reconnect
   task automatic t_manual;
      short_gnd = 2'h1;
      tick(10);
      `CHK(state_ch1, ST_FAULT_HIZ)
      short_gnd = 2'h0;
      open_in = 2'h3;
      tick(30);
      `CHK(state_ch1, ST_FAULT_LOW)
      `CHK(state_ch2, ST_FAULT_LOW)
      open_in = 2'h0;
      tick(12);
      `CHK(state_ch1, ST_NORMAL)
      `CHK(sensor_ch2, 1'b1)
   endtask

   // sleep, change sensors, wake and sample after blanking
   task automatic t_sleep;
      req_sleep = 1'b1;
      tick(1);
      req_sleep = 1'b0;
      tick(2);
      `CHK(sleep_n_out, 1'b0)
      `CHK(ready, 1'b0)
      sense = 2'h1;
      tick(1100);
      `CHK(sleep_n_out, 1'b0)
      t_wake();
      `CHK({sensor_ch2, sensor_ch1}, 2'h1)
   endtask

   task automatic conclude;
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // main sequence
   initial begin
      tick(12);
      rst = 1'b0;
      tick(1);
      t_wake();
      t_sense();
      t_restart();
      t_manual();
      t_sleep();
      conclude();
   end

   // watchdog
   initial begin
      #(40 * 20000);
      n_errors++;
      conclude();
   end
endmodule // hall_fault_sleep_supervisor_test
